/* File: design/tsr_timer.sv */
// Three counter timer with single strobe modes and clock/gate routing.
// Assumes an APB master on clk_in, a prescaled clock that is a one-cycle
// enable pulse on clk_in, and asynchronous timer pins.
//
// Function
// [RQ1] Mode 4: control word drives output high; count loads next pulse.
// [RQ2] Mode 4: at zero output low one pulse, count rolls and continues.
// [RQ3] Mode 4: strobe only on first zero after a count write.
// [RQ4] Mode 4: count N with gate high strobes N+1 pulses after write.
// [RQ5] Mode 4: low gate freezes count and output; high gate resumes.
// [RQ6] Mode 4: new count loads on next pulse and counting continues.
// [RQ7] Mode 5: control word drives output high; count loads after trigger.
// [RQ8] Mode 5: one-pulse strobe only on first zero after a load.
// [RQ9] Mode 5: count N strobes N+1 pulses after gate trigger.
// [RQ10] Mode 5: retrigger reloads next pulse; output high until zero.
// [RQ11] Mode 5: new count waits for the next gate trigger.
// [RQ12] Clock select 0 picks prescaled clock, 1 picks external pin.
// [RQ13] Counter clock must stay within half the core rate, 8 MHz max.
// [RQ14] Gate from software enable and gate bit per counter.
// [RQ15] Timer disable bit 7 blocks all counter clocks.
// [RQ16] All outputs go to interrupt logic; counter 1 requests DMA 0.
// [RQ17] Port 3 bits 0 and 1 put outputs 0 and 1 on pins.
// [RQ18] Pin config bit 5 puts counter 2 pins on package.
// [RQ19] Mode field 100 selects mode 4, 101 selects mode 5.
// [RQ20] Rollover from zero wraps to format maximum and keeps counting.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "tsr_consts.svh"

module tsr_timer
  import tsr_pkg::*;
#(
  parameter int NCTR = 3
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [17:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic prescaled_clock_in,
  input wire logic [NCTR-1:0] external_timer_clock_pin_in,
  input wire logic [NCTR-1:0] external_timer_gate_pin_in,
  input wire logic [1:0] port3_function_in,
  input wire logic coproc_function_in,
  output logic [NCTR-1:0] counter_output_out,
  output logic dma0_request_out,
  output logic [NCTR-1:0] external_timer_output_pin_out,
  output logic [NCTR-1:0] timer_pin_selected_out
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Address match against a register index
  function automatic logic addr_hit(input logic [17:0] a,
                                    input logic [15:0] idx);
    addr_hit = (a == {idx, 2'b00});
  endfunction : addr_hit

  // Decrement with wrap to the format maximum
  function automatic logic [15:0] count_dec(input logic [15:0] v,
                                            input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (bcd) begin
      for (int d = 0; d < 4; d++) begin
        if (borrow) begin
          if (r[d*4 +: 4] == 4'h0) begin
            r[d*4 +: 4] = `TSR_BCD_DIGIT_MAX;
          end else begin
            r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end else begin
      r = v - 16'h0001;
    end
    count_dec = r;
  endfunction : count_dec

  // ----------------------------------------------------------------
  // Configuration registers and APB decode
  // ----------------------------------------------------------------
  tsr_apb_req_t req;
  logic [7:0] port3_cfg_r, port3_cfg_nxt;
  logic [7:0] shared_cfg_r, shared_cfg_nxt;
  logic [7:0] route_cfg_r, route_cfg_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  tsr_route_cfg_t route;
  logic wr_en;
  logic mapped;
  logic [NCTR-1:0] ctrl_wr, count_wr, ctrl_hit, count_hit;
  tsr_ctr_t ctr_r [NCTR];
  tsr_ctr_t ctr_nxt [NCTR];

  assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in,
                 addr: paddr_in, wdata: pwdata_in};
  assign route = tsr_route_cfg_t'(route_cfg_r);
  assign wr_en = req.sel & req.enable & req.write;

  // Per-counter register hits
  always_comb begin
    for (int n = 0; n < NCTR; n++) begin
      ctrl_hit[n] = addr_hit(req.addr, `TSR_IDX_CTRL0 + 16'(n));
      count_hit[n] = addr_hit(req.addr, `TSR_IDX_COUNT0 + 16'(n));
    end
    ctrl_wr = wr_en ? ctrl_hit : '0;
    count_wr = wr_en ? count_hit : '0;
  end

  // Decode, write and read data
  always_comb begin
    port3_cfg_nxt = port3_cfg_r;
    shared_cfg_nxt = shared_cfg_r;
    route_cfg_nxt = route_cfg_r;
    prdata_nxt = prdata_r;
    mapped = addr_hit(req.addr, `TSR_IDX_PORT3_CFG) |
             addr_hit(req.addr, `TSR_IDX_SHARED_CFG) |
             addr_hit(req.addr, `TSR_IDX_ROUTE_CFG) |
             (|ctrl_hit) | (|count_hit);
    if (wr_en) begin
      if (addr_hit(req.addr, `TSR_IDX_PORT3_CFG)) begin
        port3_cfg_nxt = req.wdata[7:0];
      end
      if (addr_hit(req.addr, `TSR_IDX_SHARED_CFG)) begin
        shared_cfg_nxt = req.wdata[7:0] & `TSR_PIN_RSVD_MASK;
      end
      if (addr_hit(req.addr, `TSR_IDX_ROUTE_CFG)) begin
        route_cfg_nxt = req.wdata[7:0];
      end
    end
    // Read data captured in the setup phase
    if (req.sel & ~req.enable & ~req.write) begin
      prdata_nxt = 32'h0000_0000;
      if (addr_hit(req.addr, `TSR_IDX_PORT3_CFG)) begin
        prdata_nxt[7:0] = port3_cfg_r;
      end
      if (addr_hit(req.addr, `TSR_IDX_SHARED_CFG)) begin
        prdata_nxt[7:0] = shared_cfg_r;
      end
      if (addr_hit(req.addr, `TSR_IDX_ROUTE_CFG)) begin
        prdata_nxt[7:0] = route_cfg_r;
      end
      for (int n = 0; n < NCTR; n++) begin
        if (ctrl_hit[n]) begin
          prdata_nxt[`TSR_CTRL_MODE_LSB +: 3] = ctr_r[n].mode;
          prdata_nxt[`TSR_CTRL_BCD_BIT] = ctr_r[n].bcd;
        end
        if (count_hit[n]) begin
          prdata_nxt[15:0] = ctr_r[n].count;
          prdata_nxt[`TSR_CNT_OUT_BIT] = ctr_r[n].out;
        end
      end
    end
  end

  // Configuration and read data registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      port3_cfg_r <= `TSR_RST_CFG8;
      shared_cfg_r <= `TSR_RST_CFG8;
      route_cfg_r <= `TSR_RST_CFG8;
      prdata_r <= 32'h0000_0000;
    end else begin
      port3_cfg_r <= port3_cfg_nxt;
      shared_cfg_r <= shared_cfg_nxt;
      route_cfg_r <= route_cfg_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Zero-wait answer, error on unmapped address
  assign pready_out = 1'b1;
  assign pslverr_out = req.sel & req.enable & ~mapped;
  assign prdata_out = prdata_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock/gate routing
  // ----------------------------------------------------------------
  logic [NCTR-1:0] clk_s1_r, clk_s2_r, clk_s3_r;
  logic [NCTR-1:0] gate_s1_r, gate_s2_r;
  logic [NCTR-1:0] pin_present;
  logic [NCTR-1:0] ctr_pulse, gate_lvl;
  logic [NCTR-1:0] ck_sel, gt_sel;

  assign ck_sel = {route.clock2, route.clock1, route.clock0};
  assign gt_sel = {route.gate2, route.gate1, route.gate0};

  genvar g;
  generate
    for (g = 0; g < NCTR; g++) begin : g_pin
      // Two-stage synchroniser plus edge history
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          clk_s1_r[g] <= 1'b0;
          clk_s2_r[g] <= 1'b0;
          clk_s3_r[g] <= 1'b0;
          gate_s1_r[g] <= 1'b0;
          gate_s2_r[g] <= 1'b0;
        end else begin
          clk_s1_r[g] <= external_timer_clock_pin_in[g];
          clk_s2_r[g] <= clk_s1_r[g];
          clk_s3_r[g] <= clk_s2_r[g];
          gate_s1_r[g] <= external_timer_gate_pin_in[g];
          gate_s2_r[g] <= gate_s1_r[g];
        end
      end

      // Counter 2 pins exist only when routed to the package
      if (g == 2) begin : g_shared
        assign pin_present[g] = shared_cfg_r[`TSR_PIN_CTR2_BIT]; // RQ18
      end else begin : g_fixed
        assign pin_present[g] = 1'b1;
      end

      // Counter clock pulse source and global disable
      assign ctr_pulse[g] = ~route.timer_clocks_disable & // RQ15
        (ck_sel[g] ? (pin_present[g] & clk_s2_r[g] & ~clk_s3_r[g])
                   : prescaled_clock_in); // RQ12

      // Gate source
      assign gate_lvl[g] = route.software_gate_enable ? gt_sel[g] :
        (gt_sel[g] ? (pin_present[g] & gate_s2_r[g]) : 1'b1); // RQ14
    end
  endgenerate

  // ----------------------------------------------------------------
  // Counter engines
  // ----------------------------------------------------------------

  // Next state of every counter
  always_comb begin
    logic [15:0] dec;
    logic edge_seen;
    dec = 16'h0000;
    edge_seen = 1'b0;
    for (int n = 0; n < NCTR; n++) begin
      ctr_nxt[n] = ctr_r[n];
      dec = count_dec(ctr_r[n].count, ctr_r[n].bcd); // RQ20
      edge_seen = gate_lvl[n] & ~ctr_r[n].gate_prev;
      ctr_nxt[n].gate_prev = gate_lvl[n];
      if (ctr_pulse[n]) begin
        if (ctr_r[n].mode == `TSR_MODE_SW_STROBE) begin // RQ19
          if (ctr_r[n].load_pend) begin
            ctr_nxt[n].count = ctr_r[n].reload; // RQ1 RQ6
            ctr_nxt[n].load_pend = 1'b0;
            ctr_nxt[n].armed = 1'b1;
            ctr_nxt[n].out = 1'b1;
          end else if (gate_lvl[n]) begin // RQ5
            ctr_nxt[n].count = dec;
            ctr_nxt[n].out = 1'b1; // RQ2
            if (dec == 16'h0000 && ctr_r[n].armed) begin
              ctr_nxt[n].out = 1'b0; // RQ2 RQ4
              ctr_nxt[n].armed = 1'b0; // RQ3
            end
          end
        end else if (ctr_r[n].mode == `TSR_MODE_HW_STROBE) begin
          if (ctr_r[n].trig_pend) begin
            ctr_nxt[n].count = ctr_r[n].reload; // RQ7 RQ10
            ctr_nxt[n].trig_pend = 1'b0;
            ctr_nxt[n].armed = 1'b1;
            ctr_nxt[n].out = 1'b1;
          end else begin
            ctr_nxt[n].count = dec;
            ctr_nxt[n].out = 1'b1;
            if (dec == 16'h0000 && ctr_r[n].armed) begin
              ctr_nxt[n].out = 1'b0; // RQ8 RQ9
              ctr_nxt[n].armed = 1'b0;
            end
          end
        end
      end
      // Gate trigger set wins over consumption
      if (edge_seen && ctr_r[n].mode == `TSR_MODE_HW_STROBE) begin
        ctr_nxt[n].trig_pend = 1'b1;
      end
      // Count write: mode 5 only stores it until the next trigger
      if (count_wr[n]) begin
        ctr_nxt[n].reload = req.wdata[15:0]; // RQ11
        if (ctr_r[n].mode == `TSR_MODE_SW_STROBE) begin
          ctr_nxt[n].load_pend = 1'b1; // RQ6
        end
      end
      // Control word write disarms the counter, drops pending loads and drives output high; the count is kept
      if (ctrl_wr[n]) begin
        ctr_nxt[n].mode = req.wdata[`TSR_CTRL_MODE_LSB +: 3];
        ctr_nxt[n].bcd = req.wdata[`TSR_CTRL_BCD_BIT];
        ctr_nxt[n].out = 1'b1; // RQ1 RQ7
        ctr_nxt[n].load_pend = 1'b0;
        ctr_nxt[n].trig_pend = 1'b0;
        ctr_nxt[n].armed = 1'b0;
      end
    end
  end

  // Counter state registers
  always_ff @(posedge clk_in) begin
    for (int n = 0; n < NCTR; n++) begin
      if (reset_in) begin
        ctr_r[n] <= '{mode: 3'h0, bcd: 1'b0, count: `TSR_RST_COUNT,
                      reload: `TSR_RST_COUNT, out: 1'b1, load_pend: 1'b0,
                      trig_pend: 1'b0, armed: 1'b0, gate_prev: 1'b1};
      end else begin
        ctr_r[n] <= ctr_nxt[n];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output routing
  // ----------------------------------------------------------------
  logic [NCTR-1:0] pin_out_r, pin_out_nxt;

  // Counter outputs and pin multiplexing
  always_comb begin
    for (int n = 0; n < NCTR; n++) begin
      counter_output_out[n] = ctr_r[n].out; // RQ16
    end
    timer_pin_selected_out = '0;
    timer_pin_selected_out[0] = port3_cfg_r[`TSR_P3_TOUT0_BIT]; // RQ17
    timer_pin_selected_out[1] = port3_cfg_r[`TSR_P3_TOUT1_BIT];
    timer_pin_selected_out[2] = shared_cfg_r[`TSR_PIN_CTR2_BIT]; // RQ18
    pin_out_nxt[0] = timer_pin_selected_out[0] ? ctr_r[0].out
                                               : port3_function_in[0];
    pin_out_nxt[1] = timer_pin_selected_out[1] ? ctr_r[1].out
                                               : port3_function_in[1];
    pin_out_nxt[2] = timer_pin_selected_out[2] ? ctr_r[2].out
                                               : coproc_function_in;
  end

  // Pin output register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_out_r <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
    end
  end

  assign external_timer_output_pin_out = pin_out_r;
  assign dma0_request_out = ctr_r[1].out; // RQ16

endmodule : tsr_timer

/* File: inc/tsr_consts.svh */
// Constants for the strobe timer block: register indices, reset values,
// field positions and mode codes.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

// Register indices (byte address is four times the index)
`define TSR_IDX_PORT3_CFG 16'hf824
`define TSR_IDX_SHARED_CFG 16'hf826
`define TSR_IDX_ROUTE_CFG 16'hf834
`define TSR_IDX_CTRL0 16'hf840
`define TSR_IDX_COUNT0 16'hf844

// Reset values
`define TSR_RST_CFG8 8'h00
`define TSR_RST_COUNT 16'h0000

// Field positions
`define TSR_P3_TOUT0_BIT 0
`define TSR_P3_TOUT1_BIT 1
`define TSR_PIN_CTR2_BIT 5
`define TSR_PIN_RSVD_MASK 8'h7f
`define TSR_CTRL_BCD_BIT 0
`define TSR_CTRL_MODE_LSB 1
`define TSR_CNT_OUT_BIT 16

// Mode codes of the mode select field
`define TSR_MODE_SW_STROBE 3'b100
`define TSR_MODE_HW_STROBE 3'b101

// Count limits
`define TSR_BCD_DIGIT_MAX 4'h9

`endif

/* File: inc/tsr_pkg.sv */
// Types shared by the strobe timer block.
// Assumes tsr_consts.svh is on the include path.
package tsr_pkg;
  `include "tsr_consts.svh"

  // Timer routing configuration register layout
  typedef struct packed {
    logic timer_clocks_disable;
    logic software_gate_enable;
    logic gate2;
    logic clock2;
    logic gate1;
    logic clock1;
    logic gate0;
    logic clock0;
  } tsr_route_cfg_t;

  // APB request seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [17:0] addr;
    logic [31:0] wdata;
  } tsr_apb_req_t;

  // One counter's live state
  typedef struct packed {
    logic [2:0] mode;
    logic bcd;
    logic [15:0] count;
    logic [15:0] reload;
    logic out;
    logic load_pend;
    logic trig_pend;
    logic armed;
    logic gate_prev;
  } tsr_ctr_t;
endpackage : tsr_pkg

/* File: testbench/tb_tsr_timer.sv */
// Testbench: APB master, far-side model and queued read checks.
// Assumes the zero-wait APB slave and count read layout of the block.
`timescale 1ns/1ps
`include "tsr_consts.svh"
// ---------------------------------------------------------------
// Bench
// ---------------------------------------------------------------
module tb_tsr_timer;
  import tsr_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, prescaled_clock, dma, kick = 1'b0, src = 1'b0;
  logic [2:0] tclk, tgate, cout, pin, pinsel, gate = 3'h7;
  logic [1:0] p3fn = 2'h0;
  logic cofn = 1'b0;
  logic [15:0] n4;
  logic [32:0] exp_q[$];
  int n_fail = 0, num_checks = 0, cyc = 0;
  integer seed = 32'h45e9;
  tsr_timer u_tsr_timer (.clk_in(clk_in), .reset_in(reset_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .prescaled_clock_in(prescaled_clock),
    .external_timer_clock_pin_in(tclk), .external_timer_gate_pin_in(tgate),
    .port3_function_in(p3fn), .coproc_function_in(cofn),
    .counter_output_out(cout), .dma0_request_out(dma),
    .external_timer_output_pin_out(pin), .timer_pin_selected_out(pinsel));
  tsr_far_model u_tsr_far_model (.clk_in(clk_in), .kick_in(kick),
    .src_in(src), .gate_in(gate), .prescaled_clock_out(prescaled_clock), .tclk_out(tclk),
    .tgate_out(tgate));
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // Setup then access, held until pready is seen
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, idx, 32'h0);
  endtask : rd
  task automatic rdc(input logic [1:0] n, input logic o, input logic [15:0] c);
    rd(`TSR_IDX_COUNT0 + {14'h0, n}, {16'h0, o, c});
  endtask : rdc
  task automatic tick(input logic s);
    @(posedge clk_in);
    kick <= 1'b1;
    src <= s;
    @(posedge clk_in);
    kick <= 1'b0;
    repeat (9) @(posedge clk_in);
  endtask : tick
  task automatic setg(input int i, input logic v);
    @(posedge clk_in);
    gate[i] <= v;
    repeat (5) @(posedge clk_in);
  endtask : setg
  // Read monitor takes the oldest note at each read completion
  always @(posedge clk_in) begin
    if (psel && penable && !pwrite && pready === 1'b1)
      chk({pslverr, prdata}, exp_q.pop_front());
  end
  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    n4 = 16'(($random(seed) & 3) + 2);
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(`TSR_IDX_PORT3_CFG, 33'h0);
    rd(`TSR_IDX_SHARED_CFG, 33'h0);
    rd(`TSR_IDX_ROUTE_CFG, 33'h0);
    rd(16'h0100, {1'b1, 32'h0});
    wr(`TSR_IDX_CTRL0, 8'h08);
    @(negedge clk_in);
    chk(cout[0], 33'h1);
    wr(`TSR_IDX_COUNT0, n4[7:0]);
    for (int k = 1; k <= n4 + 3; k++) begin
      tick(1'b0);
      rdc(2'd0, k != n4 + 1, n4 - 16'(k - 1));
    end
    wr(`TSR_IDX_COUNT0, 8'h02);
    tick(1'b0);
    wr(`TSR_IDX_ROUTE_CFG, 8'h40);
    tick(1'b0);
    tick(1'b0);
    rdc(2'd0, 1'b1, 16'h2);
    wr(`TSR_IDX_ROUTE_CFG, 8'h42);
    tick(1'b0);
    rdc(2'd0, 1'b1, 16'h1);
    wr(`TSR_IDX_COUNT0, 8'h05);
    tick(1'b0);
    tick(1'b0);
    rdc(2'd0, 1'b1, 16'h4);
    wr(`TSR_IDX_ROUTE_CFG, 8'h02);
    setg(0, 1'b0);
    tick(1'b0);
    rdc(2'd0, 1'b1, 16'h4);
    setg(0, 1'b1);
    tick(1'b0);
    rdc(2'd0, 1'b1, 16'h3);
    wr(`TSR_IDX_ROUTE_CFG, 8'h80);
    tick(1'b0);
    rdc(2'd0, 1'b1, 16'h3);
    wr(`TSR_IDX_ROUTE_CFG, 8'h01);
    tick(1'b0);
    tick(1'b1);
    rdc(2'd0, 1'b1, 16'h2);
    wr(`TSR_IDX_ROUTE_CFG, 8'h08);
    setg(1, 1'b0);
    wr(`TSR_IDX_CTRL0 + 16'h1, 8'h0a);
    wr(`TSR_IDX_COUNT0 + 16'h1, 8'h02);
    tick(1'b0);
    chk(cout[1], 33'h1);
    setg(1, 1'b1);
    for (int k = 0; k < 5; k++) begin
      tick(1'b0);
      rdc(2'd1, k != 2, 16'h2 - 16'(k));
      if (k == 2) chk(dma, 33'h0);
    end
    setg(1, 1'b0);
    setg(1, 1'b1);
    tick(1'b0);
    rdc(2'd1, 1'b1, 16'h2);
    wr(`TSR_IDX_COUNT0 + 16'h1, 8'h04);
    tick(1'b0);
    tick(1'b0);
    rdc(2'd1, 1'b0, 16'h0);
    wr(`TSR_IDX_CTRL0 + 16'h1, 8'h0a);
    @(negedge clk_in);
    chk(cout[1], 33'h1);
    setg(1, 1'b0);
    setg(1, 1'b1);
    tick(1'b0);
    rdc(2'd1, 1'b1, 16'h4);
    // BCD count of zero wraps to the decimal maximum
    wr(`TSR_IDX_CTRL0, 8'h09);
    wr(`TSR_IDX_COUNT0, 8'h00);
    tick(1'b0);
    tick(1'b0);
    rdc(2'd0, 1'b1, 16'h9999);
    wr(`TSR_IDX_PORT3_CFG, 8'h03);
    wr(`TSR_IDX_SHARED_CFG, 8'ha0);
    rd(`TSR_IDX_SHARED_CFG, 33'h20);
    chk(pinsel, 33'h7);
    chk(pin, {30'h0, cout});
    wr(`TSR_IDX_PORT3_CFG, 8'h00);
    wr(`TSR_IDX_SHARED_CFG, 8'h00);
    p3fn <= 2'($random(seed));
    cofn <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(pin, {30'h0, cofn, p3fn});
    wrap_up();
  end
endmodule : tb_tsr_timer

/* File: testbench/tsr_far_model.sv */
// Far side: prescaled clock pulses, timer clock pins and gate pins.
// Assumes the bench asks for one counter clock pulse at a time.
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Pulse source
// ---------------------------------------------------------------
module tsr_far_model (
  input wire logic clk_in,
  input wire logic kick_in,
  input wire logic src_in,
  input wire logic [2:0] gate_in,
  output logic prescaled_clock_out,
  output logic [2:0] tclk_out,
  output logic [2:0] tgate_out
);
  logic [2:0] hold_r = 3'h0;
  // One pulse per request, spaced far below the rate limit
  always_ff @(posedge clk_in) begin
    prescaled_clock_out <= kick_in & ~src_in;
    if (kick_in & src_in) begin
      hold_r <= 3'h4;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end
  // Pin clock stands low between requests
  assign tclk_out = {3{hold_r != 3'h0}};
  assign tgate_out = gate_in;
endmodule : tsr_far_model

/* File: testbench/tsr_timer_asserts.sv */
// Port checker for the strobe timer: routing, pins and control writes.
// Assumes it is bound to tsr_timer and sees only its ports.
`timescale 1ns/1ps
`include "tsr_consts.svh"
// ---------------------------------------------------------------
// Checker
// ---------------------------------------------------------------
module tsr_timer_asserts
  import tsr_pkg::*;
#(
  parameter int NCTR = 3
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [17:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [1:0] port3_function_in,
  input wire logic [NCTR-1:0] counter_output_out,
  input wire logic dma0_request_out,
  input wire logic [NCTR-1:0] external_timer_output_pin_out,
  input wire logic [NCTR-1:0] timer_pin_selected_out
);
  localparam logic [17:0] A_P3 = {`TSR_IDX_PORT3_CFG, 2'b00};
  localparam logic [17:0] A_SH = {`TSR_IDX_SHARED_CFG, 2'b00};
  localparam logic [17:0] A_C0 = {`TSR_IDX_CTRL0, 2'b00};
  localparam logic [17:0] A_C1 = {`TSR_IDX_CTRL0 + 16'h1, 2'b00};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Completed write at one address
  sequence s_wr(logic [17:0] a);
    psel_in && penable_in && pwrite_in && paddr_in == a;
  endsequence
  property p_rst;
    disable iff (1'b0) reset_in |=> counter_output_out == '1;
  endproperty
  property p_dma;
    dma0_request_out == counter_output_out[1];
  endproperty
  property p_p3sel;
    s_wr(A_P3) |=> timer_pin_selected_out[1:0] == $past(pwdata_in[1:0]);
  endproperty
  property p_shsel;
    s_wr(A_SH) |=> timer_pin_selected_out[2] == $past(pwdata_in[5]);
  endproperty
  property p_pinon;
    timer_pin_selected_out[0] |=>
      external_timer_output_pin_out[0] == $past(counter_output_out[0]);
  endproperty
  property p_pinoff;
    !timer_pin_selected_out[0] |=>
      external_timer_output_pin_out[0] == $past(port3_function_in[0]);
  endproperty
  property p_pin2;
    timer_pin_selected_out[2] |=>
      external_timer_output_pin_out[2] == $past(counter_output_out[2]);
  endproperty
  property p_m4hi;
    s_wr(A_C0) ##0 pwdata_in[3:1] == 3'b100 |=> counter_output_out[0];
  endproperty
  property p_m5hi;
    s_wr(A_C1) ##0 pwdata_in[3:1] == 3'b101 |=> counter_output_out[1];
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not high");
  a_dma: assert property (p_dma) else $error("dma request");
  a_p3sel: assert property (p_p3sel) else $error("port3 sel");
  a_shsel: assert property (p_shsel) else $error("pin2 sel");
  a_pinon: assert property (p_pinon) else $error("pin0 timer");
  a_pinoff: assert property (p_pinoff) else $error("pin0 port");
  a_pin2: assert property (p_pin2) else $error("pin2 timer");
  a_m4hi: assert property (p_m4hi) else $error("mode4 high");
  a_m5hi: assert property (p_m5hi) else $error("mode5 high");
endmodule : tsr_timer_asserts

bind tsr_timer tsr_timer_asserts #(.NCTR(NCTR)) u_tsr_timer_asserts (
  .clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .port3_function_in, .counter_output_out, .dma0_request_out,
  .external_timer_output_pin_out, .timer_pin_selected_out);
